//--- core/tsci_pkg.sv
// Shared constants and types of the temperature sensor serial command interface.
package tsci_pkg;
   // Clock and conversion timing.
   localparam int CLK_PERIOD_NS       = 20;
   localparam int CONV_TIME_NS        = 8220000;
   localparam int CONV_CYCLES_DEFAULT = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int CONV_CNT_W          = 20;
   localparam logic [CONV_CNT_W-1:0] CONV_CNT_ONE = 20'h00001;

   // Data widths and calibration memory shape.
   localparam int RESULT_W   = 24;
   localparam int PROM_W     = 16;
   localparam int PROM_DEPTH = 8;
   localparam int PROM_AW    = 3;
   localparam logic [7:0] PROM_PAD = 8'h00;
   localparam logic [RESULT_W-1:0] RESULT_RESET = 24'h000000;

   // Calibration words; word 1 to word 5 are the polynomial coefficients.
   localparam logic [PROM_W-1:0] PROM_INIT [PROM_DEPTH] = '{
      16'h0000, 16'h6F1E, 16'h615E, 16'h8CB0, 16'h8017, 16'h9F4D, 16'h0000, 16'h0000
   };

   // Pin bundle positions and the value the filtered pins take at reset.
   localparam int PIN_N      = 4;
   localparam int PIN_PROTO  = 0;
   localparam int PIN_CSADDR = 1;
   localparam int PIN_SCLK   = 2;
   localparam int PIN_SDA    = 3;
   localparam logic [PIN_N-1:0] PIN_RESET = 4'hA;

   // Command bytes.
   localparam logic [7:0] CMD_RESET       = 8'h1E;
   localparam logic [7:0] CMD_CONVERT     = 8'h48;
   localparam logic [7:0] CMD_READ_RESULT = 8'h00;
   localparam logic [7:0] CMD_PROM_BASE   = 8'hA0;
   localparam logic [7:0] CMD_PROM_MASK   = 8'hF1;

   // Bus addresses chosen by the address pin, and bit counts.
   localparam logic [6:0] I2C_ADDR_PIN_HIGH = 7'h76;
   localparam logic [6:0] I2C_ADDR_PIN_LOW  = 7'h77;
   localparam logic [3:0] BITS_PER_BYTE     = 4'h8;
   localparam logic [5:0] SPI_CMD_LAST      = 6'h07;
   localparam logic [5:0] SPI_CNT_MAX       = 6'h3F;

   // Two-wire slave states, one-hot.
   typedef enum logic [6:0] {
      I2C_IDLE = 7'h01,
      I2C_ADDR = 7'h02,
      I2C_AACK = 7'h04,
      I2C_CMD  = 7'h08,
      I2C_CACK = 7'h10,
      I2C_TX   = 7'h20,
      I2C_MACK = 7'h40
   } tsci_i2c_state_t;
endpackage

//--- core/tsci_prom.sv
// Calibration word memory with a registered read port.
`timescale 1ns/1ps
module tsci_prom (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic                         clear,
   input  wire logic [tsci_pkg::PROM_AW-1:0] addr,
   output logic      [tsci_pkg::PROM_W-1:0]  rdData_q
);
   import tsci_pkg::*;

   // The read register is cleared by the reset command so a stale word never leaks out.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdData_q <= '0;
      end
      else if (clear)
      begin
         rdData_q <= '0;
      end
      else
      begin
         rdData_q <= PROM_INIT[addr];
      end
   end
endmodule

//--- core/tsci_top.sv
// Serial command interface of the temperature sensor: SPI or two-wire slave, commands, conversion.
// Function
// RULE1: Protocol pin low selects SPI slave, high selects two-wire slave.
// RULE2: Two-wire messages are framed by start and stop; address byte then command byte.
// RULE3: Address pin high gives address 1110110x, low gives 1110111x.
// RULE4: SPI frame runs from chip select falling to chip select rising.
// RULE5: SPI clock may idle low (mode 0) or high (mode 3).
// RULE6: Commands 0x1E reset, 0x48 start conversion, 0x00 read result.
// RULE7: Commands 0xA0 to 0xAE read calibration words 0 to 7, step two.
// RULE8: Same command set and encoding for SPI and two-wire.
// RULE9: Reset command returns the memory logic to a known state.
// RULE10: Calibration read is a command, then a separate data transfer.
// RULE11: Words at 0xA2 to 0xAA hold five unsigned 16-bit polynomial coefficients.
// RULE12: In SPI, last command clock starts conversion; data output goes low.
// RULE13: In SPI, data output goes high once the conversion finishes.
// RULE14: In two-wire, all commands but reset are refused while converting.
// RULE15: In two-wire, read result is acknowledged only after conversion completes.
// RULE16: Read result gives zeros without a prior conversion or when repeated.
// RULE17: Host divides the raw 24-bit value by 256 before the polynomial.
// RULE18: Data is sent MSB first; result 24 bits, calibration word 16 bits.
`timescale 1ns/1ps
module tsci_top #(
   parameter int unsigned CONV_CYCLES = tsci_pkg::CONV_CYCLES_DEFAULT
) (
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic                          protocolSelect,
   input  wire logic                          chipSelectOrAddrPin,
   input  wire logic                          serialClk,
   input  wire logic                          sdaIn,
   output logic                               sdaOut,
   output logic                               sdaOe,
   output logic                               sdoOut,
   input  wire logic [tsci_pkg::RESULT_W-1:0] rawConversionValue,
   output logic                               convBusy
);
   import tsci_pkg::*;

   logic [PIN_N-1:0]      pinRaw;
   logic [PIN_N-1:0]      sync1_q;
   logic [PIN_N-1:0]      sync2_q;
   logic [PIN_N-1:0]      sync3_q;
   logic [PIN_N-1:0]      pin_q;
   logic [PIN_N-1:0]      pinPrev_q;
   logic                  i2cMode;
   logic                  csHigh;
   logic                  sclRise;
   logic                  sclFall;
   logic                  sdaRise;
   logic                  sdaFall;
   logic                  spiActive;
   logic [5:0]            spiCnt_q;
   logic [6:0]            spiRx_q;
   logic                  spiTxEn_q;
   logic [7:0]            spiByte;
   logic                  spiFire;
   logic                  spiShift;
   tsci_i2c_state_t       st_q;
   logic [3:0]            i2cCnt_q;
   logic [7:0]            i2cRx_q;
   logic                  toTx_q;
   logic                  mAck_q;
   logic                  i2cStart;
   logic                  i2cStop;
   logic                  addrMatch;
   logic                  addrDone;
   logic                  i2cFire;
   logic                  i2cShift;
   logic                  cmdFire;
   logic [7:0]            cmdByte;
   logic                  resetCmd;
   logic                  busy_q;
   logic [CONV_CNT_W-1:0] convCnt_q;
   logic                  convDone;
   logic                  fresh_q;
   logic [RESULT_W-1:0]   result_q;
   logic                  loadProm_q;
   logic [PROM_W-1:0]     promData;
   logic [RESULT_W-1:0]   tx_q;

   // Calibration read command: high nibble A, even low nibble.
   function automatic logic isPromCmd(input logic [7:0] b);
      isPromCmd = ((b & CMD_PROM_MASK) == CMD_PROM_BASE);
   endfunction

   // Any command that is followed by a data transfer back to the host.
   function automatic logic isReadCmd(input logic [7:0] b);
      isReadCmd = isPromCmd(b) || (b == CMD_READ_RESULT);
   endfunction

   // All pins arrive from outside; three stages guard against metastability.
   assign pinRaw = {sdaIn, serialClk, chipSelectOrAddrPin, protocolSelect};
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_q   <= PIN_RESET;
         sync2_q   <= PIN_RESET;
         sync3_q   <= PIN_RESET;
         pinPrev_q <= PIN_RESET;
      end
      else
      begin
         sync1_q   <= pinRaw;
         sync2_q   <= sync1_q;
         sync3_q   <= sync2_q;
         pinPrev_q <= pin_q;
      end
   end

   // A pin change is accepted only when the last two stages agree.
   genvar g;
   generate
      for (g = 0; g < PIN_N; g++)
      begin : gFilter
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               pin_q[g] <= PIN_RESET[g];
            end
            else if (sync2_q[g] == sync3_q[g])
            begin
               pin_q[g] <= sync3_q[g];
            end
         end
      end
   endgenerate

   // Pin decode and edge detection on the filtered levels.
   assign i2cMode   = pin_q[PIN_PROTO];  // RULE1
   assign csHigh    = pin_q[PIN_CSADDR];
   assign sclRise   = pin_q[PIN_SCLK] & ~pinPrev_q[PIN_SCLK];
   assign sclFall   = ~pin_q[PIN_SCLK] & pinPrev_q[PIN_SCLK];
   assign sdaRise   = pin_q[PIN_SDA] & ~pinPrev_q[PIN_SDA];
   assign sdaFall   = ~pin_q[PIN_SDA] & pinPrev_q[PIN_SDA];
   assign spiActive = ~i2cMode & ~csHigh;  // RULE1 RULE4

   // SPI: input sampled on rising clock, so the idle level of the clock does not matter.
   assign spiByte  = {spiRx_q, pin_q[PIN_SDA]};
   assign spiFire  = spiActive & sclRise & (spiCnt_q == SPI_CMD_LAST);  // RULE12
   assign spiShift = spiActive & spiTxEn_q & sclFall;  // RULE5

   // SPI frame state; chip select high ends the frame and drops any pending data phase.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         spiCnt_q  <= '0;
         spiRx_q   <= '0;
         spiTxEn_q <= 1'b0;
      end
      else if (!spiActive)
      begin
         spiCnt_q  <= '0;  // RULE4
         spiTxEn_q <= 1'b0;
      end
      else
      begin
         if (sclRise && spiCnt_q != SPI_CNT_MAX)
         begin
            spiCnt_q <= spiCnt_q + 6'h01;
         end
         if (sclRise && spiCnt_q < SPI_CMD_LAST)
         begin
            spiRx_q <= spiByte[6:0];
         end
         if (spiFire && isReadCmd(spiByte))
         begin
            spiTxEn_q <= 1'b1;  // RULE10
         end
      end
   end

   // Two-wire bus conditions and byte decisions.
   assign i2cStart  = i2cMode & pin_q[PIN_SCLK] & pinPrev_q[PIN_SCLK] & sdaFall;  // RULE2
   assign i2cStop   = i2cMode & pin_q[PIN_SCLK] & pinPrev_q[PIN_SCLK] & sdaRise;  // RULE2
   assign addrMatch = i2cRx_q[7:1] == (csHigh ? I2C_ADDR_PIN_HIGH : I2C_ADDR_PIN_LOW);  // RULE3
   assign addrDone  = (st_q == I2C_ADDR) & sclFall & (i2cCnt_q == BITS_PER_BYTE);
   assign i2cFire   = (st_q == I2C_CMD) & sclFall & (i2cCnt_q == BITS_PER_BYTE)
                      & (~busy_q | (i2cRx_q == CMD_RESET));  // RULE14
   assign i2cShift  = sclFall & (((st_q == I2C_AACK) & toTx_q)
                      | ((st_q == I2C_TX) & (i2cCnt_q != BITS_PER_BYTE))
                      | ((st_q == I2C_MACK) & mAck_q));

   // Two-wire slave; the line is only driven low, and its drive is only switched on at a falling clock.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_q     <= I2C_IDLE;
         i2cCnt_q <= '0;
         i2cRx_q  <= '0;
         sdaOe    <= 1'b0;
         sdaOut   <= 1'b0;
         toTx_q   <= 1'b0;
         mAck_q   <= 1'b0;
      end
      else if (!i2cMode || i2cStop)
      begin
         st_q  <= I2C_IDLE;  // RULE2
         sdaOe <= 1'b0;
      end
      else if (i2cStart)
      begin
         st_q     <= I2C_ADDR;  // RULE2
         i2cCnt_q <= '0;
         sdaOe    <= 1'b0;
      end
      else
      begin
         unique case (st_q)
            I2C_IDLE: ;
            I2C_ADDR, I2C_CMD:
            begin
               if (sclRise && i2cCnt_q != BITS_PER_BYTE)
               begin
                  i2cRx_q  <= {i2cRx_q[6:0], pin_q[PIN_SDA]};
                  i2cCnt_q <= i2cCnt_q + 4'h1;
               end
               else if (addrDone)
               begin
                  // A read address is refused while converting.
                  if (addrMatch && (!i2cRx_q[0] || !busy_q))  // RULE3 RULE15
                  begin
                     sdaOe  <= 1'b1;
                     toTx_q <= i2cRx_q[0];
                     st_q   <= I2C_AACK;
                  end
                  else
                  begin
                     st_q <= I2C_IDLE;
                  end
               end
               else if (sclFall && i2cCnt_q == BITS_PER_BYTE)
               begin
                  sdaOe <= i2cFire;  // RULE14 RULE15
                  st_q  <= i2cFire ? I2C_CACK : I2C_IDLE;
               end
            end
            I2C_AACK:
            begin
               if (sclFall)
               begin
                  i2cCnt_q <= '0;
                  sdaOe    <= toTx_q & ~tx_q[RESULT_W-1];  // RULE10
                  st_q     <= toTx_q ? I2C_TX : I2C_CMD;  // RULE2
               end
            end
            I2C_CACK:
            begin
               if (sclFall)
               begin
                  sdaOe <= 1'b0;
                  st_q  <= I2C_IDLE;
               end
            end
            I2C_TX:
            begin
               if (sclRise)
               begin
                  i2cCnt_q <= i2cCnt_q + 4'h1;
               end
               else if (sclFall)
               begin
                  sdaOe <= (i2cCnt_q != BITS_PER_BYTE) & ~tx_q[RESULT_W-1];  // RULE18
                  st_q  <= (i2cCnt_q == BITS_PER_BYTE) ? I2C_MACK : I2C_TX;
               end
            end
            I2C_MACK:
            begin
               if (sclRise)
               begin
                  mAck_q <= ~pin_q[PIN_SDA];
               end
               else if (sclFall)
               begin
                  i2cCnt_q <= '0;
                  sdaOe    <= mAck_q & ~tx_q[RESULT_W-1];
                  st_q     <= mAck_q ? I2C_TX : I2C_IDLE;
               end
            end
            default: st_q <= I2C_IDLE;
         endcase
      end
   end

   // Both protocols feed one decoder, so the command set cannot differ between them.
   assign cmdFire  = spiFire | i2cFire;  // RULE8
   assign cmdByte  = spiFire ? spiByte : i2cRx_q;  // RULE8
   assign resetCmd = cmdFire & (cmdByte == CMD_RESET);  // RULE6 RULE9
   assign convDone = busy_q & (convCnt_q == CONV_CNT_ONE);
   assign convBusy = busy_q;

   // Conversion timer; a start while busy is ignored rather than restarting the count.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         busy_q    <= 1'b0;
         convCnt_q <= '0;
      end
      else if (resetCmd)
      begin
         busy_q    <= 1'b0;  // RULE9
         convCnt_q <= '0;
      end
      else if (cmdFire && cmdByte == CMD_CONVERT && !busy_q)
      begin
         busy_q    <= 1'b1;  // RULE6 RULE12
         convCnt_q <= CONV_CNT_W'(CONV_CYCLES);
      end
      else if (convDone)
      begin
         busy_q    <= 1'b0;
         convCnt_q <= '0;
      end
      else if (busy_q)
      begin
         convCnt_q <= convCnt_q - CONV_CNT_ONE;
      end
   end

   // Result is fresh from completion until its first read; completion wins over a read.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         fresh_q  <= 1'b0;
         result_q <= RESULT_RESET;
      end
      else if (resetCmd)
      begin
         fresh_q  <= 1'b0;  // RULE9
         result_q <= RESULT_RESET;
      end
      else if (convDone)
      begin
         fresh_q  <= 1'b1;
         result_q <= rawConversionValue;
      end
      else if (cmdFire && cmdByte == CMD_READ_RESULT)
      begin
         fresh_q <= 1'b0;  // RULE16
      end
   end

   // Calibration word fetch takes one cycle through the memory read register.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         loadProm_q <= 1'b0;
      end
      else
      begin
         loadProm_q <= cmdFire & isPromCmd(cmdByte);  // RULE7
      end
   end

   tsci_prom uProm (
      .clk      (clk),
      .rst      (rst),
      .clear    (resetCmd),
      .addr     (cmdByte[3:1]),
      .rdData_q (promData)
   );

   // Shared transmit register, left aligned so both protocols send the MSB first.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_q <= '0;
      end
      else if (resetCmd)
      begin
         tx_q <= '0;  // RULE9
      end
      else if (cmdFire && cmdByte == CMD_READ_RESULT)
      begin
         tx_q <= fresh_q ? result_q : RESULT_RESET;  // RULE16
      end
      else if (loadProm_q)
      begin
         tx_q <= {promData, PROM_PAD};  // RULE11 RULE18
      end
      else if (spiShift || i2cShift)
      begin
         tx_q <= {tx_q[RESULT_W-2:0], 1'b0};  // RULE18
      end
   end

   // Outside a data phase the SPI output shows conversion status: low busy, high done.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sdoOut <= 1'b1;
      end
      else if (spiTxEn_q)
      begin
         if (spiShift)
         begin
            sdoOut <= tx_q[RESULT_W-1];  // RULE18
         end
      end
      else
      begin
         sdoOut <= ~busy_q;  // RULE12 RULE13
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_convStart;
      cmdFire && cmdByte == CMD_CONVERT && !busy_q && !resetCmd |=> busy_q ##1 !sdoOut;
   endproperty
   a_convStart: assert property (p_convStart) else $error("Start did not set busy."); // RULE12

   property p_convEnd;
      convDone && !spiTxEn_q |=> !busy_q ##1 (sdoOut || spiTxEn_q);
   endproperty
   a_convEnd: assert property (p_convEnd) else $error("Done not shown on SPI output."); // RULE13

   property p_staleRead;
      cmdFire && cmdByte == CMD_READ_RESULT && !fresh_q && !convDone
         |=> tx_q == RESULT_RESET && !fresh_q;
   endproperty
   a_staleRead: assert property (p_staleRead) else $error("Stale read not zero."); // RULE16

   property p_freshRead;
      cmdFire && cmdByte == CMD_READ_RESULT && fresh_q && !convDone
         |=> tx_q == $past(result_q) && !fresh_q;
   endproperty
   a_freshRead: assert property (p_freshRead) else $error("Fresh read wrong."); // RULE16

   property p_resetCmd;
      resetCmd |=> !busy_q && !fresh_q && tx_q == RESULT_RESET && promData == '0;
   endproperty
   a_resetCmd: assert property (p_resetCmd) else $error("Reset command incomplete."); // RULE9

   property p_busyRefuse;
      st_q == I2C_CMD && sclFall && i2cCnt_q == BITS_PER_BYTE && busy_q
         && i2cRx_q != CMD_RESET && i2cMode && !i2cStop |=> st_q == I2C_IDLE && !sdaOe && !cmdFire;
   endproperty
   a_busyRefuse: assert property (p_busyRefuse) else $error("Command taken while busy."); // RULE14

   property p_addrAck;
      addrDone && addrMatch && !i2cRx_q[0] && i2cMode |=> sdaOe && st_q == I2C_AACK;
   endproperty
   a_addrAck: assert property (p_addrAck) else $error("Own address not acked."); // RULE3

   property p_readBusy;
      addrDone && i2cRx_q[0] && busy_q && i2cMode |=> !sdaOe && st_q == I2C_IDLE;
   endproperty
   a_readBusy: assert property (p_readBusy) else $error("Read acked while busy."); // RULE15

   property p_promLoad;
      loadProm_q && !resetCmd && !cmdFire |=> tx_q[RESULT_W-1 -: PROM_W] == $past(promData);
   endproperty
   a_promLoad: assert property (p_promLoad) else $error("Word not loaded."); // RULE7

   property p_msbFirst;
      spiShift |=> sdoOut == $past(tx_q[RESULT_W-1]);
   endproperty
   a_msbFirst: assert property (p_msbFirst) else $error("SPI bit order wrong."); // RULE18

   property p_frameEnd;
      csHigh |=> spiCnt_q == '0 && !spiTxEn_q;
   endproperty
   a_frameEnd: assert property (p_frameEnd) else $error("Frame not closed."); // RULE4

   property p_modeSel;
      i2cMode |-> !spiFire && !spiShift;
   endproperty
   a_modeSel: assert property (p_modeSel) else $error("SPI active in two-wire mode."); // RULE1

   c_convDone: cover property (convDone);
   c_i2cRead: cover property (st_q == I2C_MACK && sclFall && mAck_q);
   c_spiProm: cover property (loadProm_q && spiTxEn_q);
endmodule

//--- test/tsci_host_model.sv
// Host master model that drives the sensor pins over SPI or two-wire.
`timescale 1ns/1ps
module tsci_host_model (
   input  wire logic        clk,
   input  wire logic        sdaOe,
   input  wire logic        sdoOut,
   output logic             protocolSelect,
   output logic             csAddrPin,
   output logic             serialClk,
   output logic             sdaLine,
   output logic             rxStrobe,
   output logic [23:0]      rxData
);
   logic        hostSda;
   logic [15:0] scaledValue;

   // Open-drain wire with a pull-up: whoever pulls low wins.
   assign sdaLine = hostSda & ~sdaOe;

   // Idle levels; chip select stays high across reset to avoid a stray clock edge.
   initial
   begin
      protocolSelect = 1'b0;
      csAddrPin = 1'b1;
      serialClk = 1'b0;
      hostSda = 1'b1;
      rxStrobe = 1'b0;
      rxData = 24'h000000;
   end

   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Hands a collected result to the watcher for one cycle; the host scales it as well.
   task automatic give(input logic [23:0] d);
      scaledValue = d[23:8];
      rxData <= d;
      rxStrobe <= 1'b1;
      tk(1);
      rxStrobe <= 1'b0;
   endtask

   // One frame: command MSB first, then n data bits taken late in the high half,
   // because the device sees each clock edge only after its pin filter.
   task automatic spiFrame(input logic m3, input logic [7:0] cmd, input int n);
      logic [7:0]  sh;
      logic [23:0] acc;
      sh = cmd;
      acc = 24'h000000;
      serialClk <= m3;
      tk(2);
      csAddrPin <= 1'b0;
      tk(6);
      for (int i = 0; i < 8 + n; i++)
      begin
         serialClk <= 1'b0;
         hostSda <= sh[7];
         sh = {sh[6:0], ~sh[0]};
         tk(4);
         serialClk <= 1'b1;
         tk(3);
         @(negedge clk);
         if (i >= 8)
            acc = {acc[22:0], sdoOut};
         tk(1);
      end
      serialClk <= m3;
      tk(4);
      csAddrPin <= 1'b1;
      hostSda <= ~hostSda;
      tk(8);
      if (n > 0)
         give(acc);
   endtask

   // Start is lvl(1,0,0) and stop is lvl(0,1,1): the second data move comes while the clock is high.
   task automatic lvl(input logic a, input logic b, input logic c);
      hostSda <= a;
      tk(8);
      serialClk <= 1'b1;
      tk(8);
      hostSda <= b;
      tk(8);
      serialClk <= c;
   endtask

   // Eight bits and the acknowledge slot, each sampled near the end of the high half.
   task automatic i2cBits(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--)
      begin
         tk(2);
         hostSda <= tx[i];
         tk(6);
         serialClk <= 1'b1;
         tk(7);
         @(negedge clk);
         rx[i] = sdaLine;
         tk(1);
         serialClk <= 1'b0;
      end
   endtask

   // One message: address byte, then a command byte or nb read bytes, last one refused.
   task automatic i2cXfer(input logic [6:0] a, input logic rd, input logic [7:0] c,
                          input int nb, output logic ackA, output logic ackC);
      logic [8:0]  r;
      logic [23:0] acc;
      acc = 24'h000000;
      lvl(1'b1, 1'b0, 1'b0);
      i2cBits({a, rd, 1'b1}, r);
      ackA = ~r[0];
      ackC = 1'b0;
      for (int k = 0; ackA && k < nb; k++)
      begin
         i2cBits(rd ? {8'hFF, k == nb - 1} : {c, 1'b1}, r);
         acc = {acc[15:0], r[8:1]};
         ackC = ~r[0];
      end
      lvl(1'b0, 1'b1, 1'b1);
      if (rd && ackA)
         give(acc);
   endtask
endmodule

//--- test/tsci_top_test.sv
// Self-checking bench of the sensor command interface in SPI and two-wire mode.
`timescale 1ns/1ps
module tsci_top_test;
   import tsci_pkg::*;
   localparam int CONV_N = 2000;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic                protocolSelect, csAddrPin, serialClk, sdaLine, ackA, ackC;
   logic                sdaOut, sdaOe, sdoOut, convBusy, rxStrobe;
   logic [RESULT_W-1:0] rawValue = 24'h000000;
   logic [RESULT_W-1:0] rxData;
   logic [RESULT_W-1:0] expQ [$];
   int                  n_fail = 0;
   int                  checked = 0;
   int                  cycles = 0;

   tsci_top #(.CONV_CYCLES(CONV_N)) i_tsci_top (.clk(clk), .rst(rst),
      .protocolSelect(protocolSelect), .chipSelectOrAddrPin(csAddrPin),
      .serialClk(serialClk), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .sdoOut(sdoOut), .rawConversionValue(rawValue), .convBusy(convBusy));
   tsci_host_model i_tsci_host_model (.clk(clk), .sdaOe(sdaOe), .sdoOut(sdoOut),
      .protocolSelect(protocolSelect), .csAddrPin(csAddrPin), .serialClk(serialClk),
      .sdaLine(sdaLine), .rxStrobe(rxStrobe), .rxData(rxData));

   // Free-running 50 MHz clock.
   always #10 clk = ~clk;

   task automatic chkData(input string what, input logic [23:0] e, input logic [23:0] g);
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chkBit(input string what, input logic e, input logic g);
      chkData(what, {23'h000000, e}, {23'h000000, g});
   endtask

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Matches each collected result with the oldest note; also cuts a hang short.
   always @(posedge clk)
   begin
      cycles++;
      if (rxStrobe === 1'b1 && expQ.size() == 0)
         chkBit("unexpected read", 1'b0, 1'b1);
      else if (rxStrobe === 1'b1)
         chkData("read data", expQ.pop_front(), rxData);
      if (cycles == 60000)
      begin
         n_fail++;
         report_and_stop();
      end
   end

   task automatic spi(input logic m3, input logic [7:0] c, input int n, input logic [23:0] e);
      if (n > 0)
         expQ.push_back(e);
      i_tsci_host_model.spiFrame(m3, c, n);
   endtask

   task automatic i2c(input logic [6:0] a, input logic rd, input logic [7:0] c, input int nb,
                      input logic eA, input logic eC, input logic [23:0] e);
      if (rd && eA)
         expQ.push_back(e);
      i_tsci_host_model.i2cXfer(a, rd, c, nb, ackA, ackC);
      chkBit("address ack", eA, ackA);
      chkBit("SDA drive level", 1'b0, sdaOut);
      if (!rd)
         chkBit("command ack", eC, ackC);
   endtask

   // Bounded wait for the end of a conversion; the ready level must follow.
   task automatic waitDone(output int k);
      k = 0;
      while (convBusy !== 1'b0 && k < CONV_N + 50)
      begin
         @(negedge clk);
         k++;
      end
      repeat (3) @(negedge clk);
      chkBit("SDO ready level", 1'b1, sdoOut);
      @(posedge clk);
   endtask

   // Main sequence: SPI commands in both clock modes, then the two-wire link.
   initial
   begin
      int k;
      void'($urandom(52708));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      spi(1'b0, 8'h1E, 0, 24'h000000);
      spi(1'b0, 8'h00, 24, 24'h000000);
      for (int i = 0; i < 8; i++)
         spi(i[0], 8'hA0 + 8'(2 * i), 16, {8'h00, PROM_INIT[i]});
      rawValue <= 24'($urandom);
      spi(1'b1, 8'h48, 0, 24'h000000);
      @(negedge clk);
      chkBit("busy after convert", 1'b1, convBusy);
      chkBit("SDO busy level", 1'b0, sdoOut);
      chkBit("SDA enable in SPI", 1'b0, sdaOe);
      waitDone(k);
      chkBit("conversion length", 1'b1, k >= CONV_N - 20 && k <= CONV_N);
      spi(1'b1, 8'h00, 24, rawValue);
      spi(1'b0, 8'h00, 24, 24'h000000);
      spi(1'b0, 8'h48, 0, 24'h000000);
      spi(1'b0, 8'h1E, 0, 24'h000000);
      @(negedge clk);
      chkBit("busy after reset", 1'b0, convBusy);
      $display("SPI tests done");
      @(posedge clk);
      i_tsci_host_model.protocolSelect <= 1'b1;
      repeat (10) @(posedge clk);
      rawValue <= 24'($urandom);
      i2c(7'h76, 1'b0, 8'h48, 1, 1'b1, 1'b1, 24'h000000);
      i2c(7'h76, 1'b0, 8'h00, 1, 1'b1, 1'b0, 24'h000000);
      i2c(7'h76, 1'b1, 8'h00, 3, 1'b0, 1'b0, 24'h000000);
      i2c(7'h77, 1'b0, 8'h00, 1, 1'b0, 1'b0, 24'h000000);
      waitDone(k);
      i2c(7'h76, 1'b0, 8'h00, 1, 1'b1, 1'b1, 24'h000000);
      i2c(7'h76, 1'b1, 8'h00, 3, 1'b1, 1'b0, rawValue);
      i2c(7'h76, 1'b0, 8'h00, 1, 1'b1, 1'b1, 24'h000000);
      i2c(7'h76, 1'b1, 8'h00, 3, 1'b1, 1'b0, 24'h000000);
      i2c(7'h76, 1'b0, 8'hA6, 1, 1'b1, 1'b1, 24'h000000);
      i2c(7'h76, 1'b1, 8'h00, 2, 1'b1, 1'b0, {8'h00, PROM_INIT[3]});
      i2c(7'h76, 1'b0, 8'h48, 1, 1'b1, 1'b1, 24'h000000);
      i2c(7'h76, 1'b0, 8'h1E, 1, 1'b1, 1'b1, 24'h000000);
      @(negedge clk);
      chkBit("busy after reset", 1'b0, convBusy);
      @(posedge clk);
      i_tsci_host_model.csAddrPin <= 1'b0;
      repeat (10) @(posedge clk);
      i2c(7'h76, 1'b0, 8'h00, 1, 1'b0, 1'b0, 24'h000000);
      i2c(7'h77, 1'b0, 8'h00, 1, 1'b1, 1'b1, 24'h000000);
      i2c(7'h77, 1'b1, 8'h00, 3, 1'b1, 1'b0, 24'h000000);
      $display("two-wire tests done");
      repeat (4) @(posedge clk);
      chkBit("all reads seen", 1'b1, expQ.size() == 0);
      report_and_stop();
   end
endmodule
